// ==== hw/cfg_pkg.sv ====
// Constants, field layouts and carrier types of the wake and interrupt configuration block.
package cfg_pkg;

    // Serial frame layout.
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned FLAG_BITS = 8;
    localparam int unsigned CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
    localparam logic [CNT_W-1:0] FLAG_LEN = 5'h08;
    localparam logic [CNT_W-1:0] ADDR_LAST_CNT = 5'h06;
    localparam int unsigned RW_BIT = 15;
    localparam int unsigned ADDR_W = 6;

    // Register addresses as carried in the frame.
    localparam logic [ADDR_W-1:0] ADDR_WAKE_CFG = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CFG = 6'h04;

    // Reset values (power-on only) and the writable bits of the wake register.
    localparam logic [7:0] WAKE_CFG_RESET = 8'h00;
    localparam logic [7:0] IRQ_CFG_RESET = 8'h00;
    localparam logic [7:0] WAKE_WRITE_MASK = 8'hF7;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Wake selections for the pin five input.
    localparam logic [1:0] WAKE_NONE = 2'h0;
    localparam logic [1:0] WAKE_HIGH = 2'h1;
    localparam logic [1:0] WAKE_LOW = 2'h2;
    localparam logic [1:0] WAKE_ANY = 2'h3;

    // Times in nanoseconds and their counts at the system clock.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CAN_TO_SHORT_NS = 120000;
    localparam int unsigned CAN_TO_LONG_NS = 2800000;
    localparam int unsigned INT_LONG_NS = 100000;
    localparam int unsigned INT_SHORT_NS = 25000;
    localparam int unsigned CAN_TO_SHORT_CYC = CAN_TO_SHORT_NS / CLK_PERIOD_NS;
    localparam int unsigned CAN_TO_LONG_CYC = CAN_TO_LONG_NS / CLK_PERIOD_NS;
    localparam int unsigned INT_LONG_CYC = INT_LONG_NS / CLK_PERIOD_NS;
    localparam int unsigned INT_SHORT_CYC = INT_SHORT_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 22;

    typedef enum logic [1:0] {SLEW_20K, SLEW_10K, SLEW_FAST} lin_slew_e;

    typedef struct packed {
        logic [1:0] pin5_wake_select;
        logic can_disable_sleep;
        logic can_wake_timeout_select;
        logic reserved;
        logic lin_undervoltage_recessive_disable;
        logic [1:0] lin_slew_select;
    } wake_cfg_s;

    typedef struct packed {
        logic int_short_pulse;
        logic lin_error_irq_mask;
        logic global_irq_mask;
        logic sense_uv_irq_mask;
        logic preregulator_irq_mask;
        logic core_supply_irq_mask;
        logic aux_supplies_irq_mask;
        logic can_error_irq_mask;
    } irq_cfg_s;

    // One-cycle event strobes from the interrupt sources.
    typedef struct packed {
        logic other;
        logic lin_error;
        logic sense_uv;
        logic preregulator;
        logic core_supply;
        logic aux_supplies;
        logic can_error;
    } irq_events_s;

endpackage : cfg_pkg

// ==== hw/wake_and_interrupt_config.sv ====
// Wake, transceiver and interrupt configuration registers behind the serial port.
`timescale 1ns/1ps
`default_nettype none

module wake_and_interrupt_config #(
    parameter int unsigned CAN_TO_SHORT_CYCLES = cfg_pkg::CAN_TO_SHORT_CYC,
    parameter int unsigned CAN_TO_LONG_CYCLES = cfg_pkg::CAN_TO_LONG_CYC,
    parameter int unsigned INT_LONG_CYCLES = cfg_pkg::INT_LONG_CYC,
    parameter int unsigned INT_SHORT_CYCLES = cfg_pkg::INT_SHORT_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic frame_reset,
    input wire logic spi_cs_b,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic [cfg_pkg::FLAG_BITS-1:0] global_flags,
    output logic frame_error,
    input wire logic io5_level,
    output logic io5_wake,
    input wire logic failsafe_output_b,
    input wire logic failsafe_affects_can,
    output logic can_rx_only,
    output logic can_sleep,
    input wire logic can_wake_pattern_active,
    output logic can_wake_timeout,
    input wire logic battery_supply_below_7v,
    output logic lin_force_recessive,
    output cfg_pkg::lin_slew_e lin_slew_mode,
    input wire cfg_pkg::irq_events_s irq_events,
    output logic int_b
);
    import cfg_pkg::*;

    localparam logic [TIMER_W-1:0] CAN_SHORT = TIMER_W'(CAN_TO_SHORT_CYCLES);
    localparam logic [TIMER_W-1:0] CAN_LONG = TIMER_W'(CAN_TO_LONG_CYCLES);
    localparam logic [TIMER_W-1:0] INT_LONG = TIMER_W'(INT_LONG_CYCLES);
    localparam logic [TIMER_W-1:0] INT_SHORT = TIMER_W'(INT_SHORT_CYCLES);
    localparam logic [TIMER_W-1:0] TIMER_ONE = TIMER_W'(1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = TIMER_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // Readback of the register at the given address; unmapped reads as zero.
    function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] addr,
                                            input wake_cfg_s wake, input irq_cfg_s irq);
        logic [7:0] val;
        val = READ_UNMAPPED;
        if (addr == ADDR_WAKE_CFG) begin
            val = wake & WAKE_WRITE_MASK;
        end else if (addr == ADDR_IRQ_CFG) begin
            val = irq;
        end
        return val;
    endfunction : read_reg

    // Serial port state.
    logic sclk_q, sclk_d;
    logic cs_b_q, cs_b_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [FRAME_BITS-1:0] rx_q, rx_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [FLAG_BITS-1:0] flags_q, flags_d;
    logic miso_q, miso_d;
    logic write_q, write_d;
    logic err_q, err_d;

    // Configuration registers.
    wake_cfg_s wake_cfg_q, wake_cfg_d;
    irq_cfg_s irq_cfg_q, irq_cfg_d;

    // Behaviour outputs.
    logic io5_prev_q, io5_prev_d;
    logic io5_wake_q, io5_wake_d;
    logic can_rx_only_q, can_rx_only_d;
    logic can_sleep_q, can_sleep_d;
    logic lin_rec_q, lin_rec_d;
    lin_slew_e slew_q, slew_d;

    // Timers.
    logic [TIMER_W-1:0] can_cnt_q, can_cnt_d;
    logic can_to_q, can_to_d;
    logic [TIMER_W-1:0] irq_cnt_q, irq_cnt_d;
    logic int_b_q, int_b_d;

    logic sclk_rise, sclk_fall, cs_fall, cs_rise;
    logic parity_ok, addr_mapped;
    logic [7:0] readback;
    logic [TIMER_W-1:0] can_limit, int_width;
    logic irq_fire;

    // Serial port: data is sampled on the falling clock edge and shifted out on the rising one.
    always_comb begin
        sclk_rise = spi_sclk & ~sclk_q;
        sclk_fall = ~spi_sclk & sclk_q;
        cs_fall = ~spi_cs_b & cs_b_q;
        cs_rise = spi_cs_b & ~cs_b_q;
        parity_ok = ^rx_q;
        addr_mapped = (addr_q == ADDR_WAKE_CFG) || (addr_q == ADDR_IRQ_CFG);
        readback = read_reg(addr_q, wake_cfg_q, irq_cfg_q);
        sclk_d = spi_sclk;
        cs_b_d = spi_cs_b;
        cnt_d = cnt_q;
        rx_d = rx_q;
        addr_d = addr_q;
        flags_d = flags_q;
        miso_d = miso_q;
        write_d = 1'b0;
        err_d = 1'b0;
        if (frame_reset) begin
            cnt_d = '0;
            rx_d = '0;
            addr_d = '0;
            miso_d = 1'b0;
        end else if (cs_fall) begin
            // Flags are frozen at frame start so the host sees one coherent snapshot.
            cnt_d = '0;
            rx_d = '0;
            flags_d = global_flags;
            miso_d = 1'b0;
        end else if (!spi_cs_b) begin
            if (sclk_fall && cnt_q < FRAME_LEN) begin
                rx_d = {rx_q[FRAME_BITS-2:0], spi_mosi};
                cnt_d = cnt_q + CNT_ONE;
                if (cnt_q == ADDR_LAST_CNT) begin
                    addr_d = {rx_q[ADDR_W-2:0], spi_mosi};
                end
            end
            if (sclk_rise) begin
                if (cnt_q < FLAG_LEN) begin
                    miso_d = flags_q[3'(FLAG_LEN - CNT_ONE - cnt_q)];
                end else if (cnt_q < FRAME_LEN) begin
                    miso_d = readback[3'(FRAME_LEN - CNT_ONE - cnt_q)];
                end else begin
                    miso_d = 1'b0;
                end
            end
        end else if (cs_rise) begin
            // Only a whole frame with good odd parity may change a register.
            write_d = (cnt_q == FRAME_LEN) && rx_q[RW_BIT] && parity_ok && addr_mapped;
            err_d = (cnt_q != FRAME_LEN) || (rx_q[RW_BIT] && !parity_ok);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
            cs_b_q <= 1'b1;
            cnt_q <= '0;
            rx_q <= '0;
            addr_q <= '0;
            flags_q <= '0;
            miso_q <= 1'b0;
            write_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            sclk_q <= sclk_d;
            cs_b_q <= cs_b_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            addr_q <= addr_d;
            flags_q <= flags_d;
            miso_q <= miso_d;
            write_q <= write_d;
            err_q <= err_d;
        end
    end

    // Configuration registers; frame_reset leaves them alone, only rstn restores them.
    always_comb begin
        wake_cfg_d = wake_cfg_q;
        irq_cfg_d = irq_cfg_q;
        if (write_q) begin
            if (addr_q == ADDR_WAKE_CFG) begin
                wake_cfg_d = rx_q[7:0] & WAKE_WRITE_MASK;
            end else if (addr_q == ADDR_IRQ_CFG) begin
                irq_cfg_d = rx_q[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wake_cfg_q <= WAKE_CFG_RESET;
            irq_cfg_q <= IRQ_CFG_RESET;
        end else begin
            wake_cfg_q <= wake_cfg_d;
            irq_cfg_q <= irq_cfg_d;
        end
    end

    // Pin wake, CAN fail-safe behaviour and LIN settings.
    always_comb begin
        io5_prev_d = io5_level;
        case (wake_cfg_q.pin5_wake_select)
            WAKE_HIGH: io5_wake_d = io5_level;
            WAKE_LOW: io5_wake_d = ~io5_level;
            WAKE_ANY: io5_wake_d = io5_level ^ io5_prev_q;
            default: io5_wake_d = 1'b0;
        endcase
        can_rx_only_d = ~failsafe_output_b & failsafe_affects_can
                        & ~wake_cfg_q.can_disable_sleep;
        can_sleep_d = ~failsafe_output_b & failsafe_affects_can
                      & wake_cfg_q.can_disable_sleep;
        lin_rec_d = battery_supply_below_7v
                    & ~wake_cfg_q.lin_undervoltage_recessive_disable;
        if (wake_cfg_q.lin_slew_select[1]) begin
            slew_d = SLEW_FAST;
        end else if (wake_cfg_q.lin_slew_select[0]) begin
            slew_d = SLEW_10K;
        end else begin
            slew_d = SLEW_20K;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            io5_prev_q <= 1'b0;
            io5_wake_q <= 1'b0;
            can_rx_only_q <= 1'b0;
            can_sleep_q <= 1'b0;
            lin_rec_q <= 1'b0;
            slew_q <= SLEW_20K;
        end else begin
            io5_prev_q <= io5_prev_d;
            io5_wake_q <= io5_wake_d;
            can_rx_only_q <= can_rx_only_d;
            can_sleep_q <= can_sleep_d;
            lin_rec_q <= lin_rec_d;
            slew_q <= slew_d;
        end
    end

    // CAN wake timeout and interrupt pulse timers.
    always_comb begin
        can_limit = wake_cfg_q.can_wake_timeout_select ? CAN_LONG : CAN_SHORT;
        int_width = irq_cfg_q.int_short_pulse ? INT_SHORT : INT_LONG;
        irq_fire = ~irq_cfg_q.global_irq_mask & (
                   irq_events.other
                   | (irq_events.lin_error & ~irq_cfg_q.lin_error_irq_mask)
                   | (irq_events.sense_uv & ~irq_cfg_q.sense_uv_irq_mask)
                   | (irq_events.preregulator & ~irq_cfg_q.preregulator_irq_mask)
                   | (irq_events.core_supply & ~irq_cfg_q.core_supply_irq_mask)
                   | (irq_events.aux_supplies & ~irq_cfg_q.aux_supplies_irq_mask)
                   | (irq_events.can_error & ~irq_cfg_q.can_error_irq_mask));
        can_cnt_d = can_cnt_q;
        can_to_d = 1'b0;
        if (!can_wake_pattern_active) begin
            can_cnt_d = TIMER_ZERO;
        end else if (can_cnt_q < can_limit) begin
            can_cnt_d = can_cnt_q + TIMER_ONE;
            can_to_d = (can_cnt_q == can_limit - TIMER_ONE);
        end
        // Events during a running pulse merge into it rather than queue a second one.
        irq_cnt_d = irq_cnt_q;
        if (irq_cnt_q != TIMER_ZERO) begin
            irq_cnt_d = irq_cnt_q - TIMER_ONE;
        end else if (irq_fire) begin
            irq_cnt_d = int_width;
        end
        int_b_d = (irq_cnt_d == TIMER_ZERO);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            can_cnt_q <= '0;
            can_to_q <= 1'b0;
            irq_cnt_q <= '0;
            int_b_q <= 1'b1;
        end else begin
            can_cnt_q <= can_cnt_d;
            can_to_q <= can_to_d;
            irq_cnt_q <= irq_cnt_d;
            int_b_q <= int_b_d;
        end
    end

    assign spi_miso = miso_q;
    assign spi_miso_oe = ~cs_b_q;
    assign frame_error = err_q;
    assign io5_wake = io5_wake_q;
    assign can_rx_only = can_rx_only_q;
    assign can_sleep = can_sleep_q;
    assign can_wake_timeout = can_to_q;
    assign lin_force_recessive = lin_rec_q;
    assign lin_slew_mode = slew_q;
    assign int_b = int_b_q;

endmodule : wake_and_interrupt_config
`default_nettype wire

// ==== verification/wake_and_interrupt_config_properties.sv ====
// Port-level assertions for the wake and interrupt configuration block.
`timescale 1ns/1ps
`default_nettype none
module wake_and_interrupt_config_properties #(
    parameter int unsigned INT_LONG_CYCLES = 16,
    parameter int unsigned INT_SHORT_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic spi_cs_b,
    input wire logic spi_miso_oe,
    input wire logic failsafe_output_b,
    input wire logic failsafe_affects_can,
    input wire logic can_rx_only,
    input wire logic can_sleep,
    input wire logic can_wake_pattern_active,
    input wire logic can_wake_timeout,
    input wire logic battery_supply_below_7v,
    input wire logic lin_force_recessive,
    input wire cfg_pkg::irq_events_s irq_events,
    input wire logic int_b
);
    import cfg_pkg::*;
    int unsigned low_d;
    int unsigned low_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Counts sampled low cycles, so a pulse width is judged when the pulse ends.
    always_comb low_d = int_b ? 0 : low_q + 1;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            low_q <= 0;
        end else begin
            low_q <= low_d;
        end
    end
    property p_can_idle;
        failsafe_output_b || !failsafe_affects_can |=> !can_rx_only && !can_sleep;
    endproperty
    a_can_idle: assert property (p_can_idle) else $error("CAN forced without fail-safe");
    property p_can_act;
        !failsafe_output_b && failsafe_affects_can |=> can_rx_only != can_sleep;
    endproperty
    a_can_act: assert property (p_can_act) else $error("CAN fail-safe mode not single");
    property p_lin_ok; !battery_supply_below_7v |=> !lin_force_recessive; endproperty
    a_lin_ok: assert property (p_lin_ok) else $error("LIN recessive above threshold");
    property p_int_width;
        $rose(int_b) |-> low_q == INT_SHORT_CYCLES || low_q == INT_LONG_CYCLES;
    endproperty
    a_int_width: assert property (p_int_width) else $error("interrupt pulse width wrong");
    property p_int_cause; $fell(int_b) |-> $past(|irq_events); endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without event");
    property p_to_cause; can_wake_timeout |-> $past(can_wake_pattern_active); endproperty
    a_to_cause: assert property (p_to_cause) else $error("timeout while idle");
    property p_to_once; can_wake_timeout |=> !can_wake_timeout; endproperty
    a_to_once: assert property (p_to_once) else $error("timeout pulse too long");
    property p_oe; spi_miso_oe == !$past(spi_cs_b); endproperty
    a_oe: assert property (p_oe) else $error("output enable not following select");
endmodule : wake_and_interrupt_config_properties
`default_nettype wire

// ==== verification/spi_host_model.sv ====
// Host serial master model: clocks one frame per call, MSB first.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic sys_clk,
    output logic spi_cs_b,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial begin
        spi_cs_b = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end
    // Clock phases are held for at least two system cycles (three high, two low) so oversampling never misses one.
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge sys_clk) spi_cs_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        for (int i = nbits - 1; i >= 0; i--) begin
            spi_sclk = 1'b1;
            spi_mosi = tx[i];
            repeat (3) @(negedge sys_clk);
            rx = {rx[14:0], spi_miso};
            spi_sclk = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        spi_mosi = ~spi_mosi;
        spi_cs_b = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== verification/wake_and_interrupt_config_tb.sv ====
// Self-checking bench: a host model sends frames and a reference model predicts each result.
`timescale 1ns/1ps
`default_nettype none
module wake_and_interrupt_config_tb;
    import cfg_pkg::*;
    // Short counts keep the run brief; every timeout and pulse width expectation is derived from these.
    localparam int TO_S = 20;
    localparam int TO_L = 50;
    localparam int IL = 16;
    localparam int IS = 4;
    logic sys_clk = 1'b0, rstn = 1'b0, frame_reset = 1'b0, cs_b, sclk, mosi, miso, oe, ferr;
    logic io5 = 1'b0, wake, fs_b = 1'b1, fs_can = 1'b0, rx_only, sleep, act = 1'b0, to, uv = 1'b0;
    logic rec, int_b;
    logic [7:0] flags = 8'h00, d;
    logic [15:0] rx;
    lin_slew_e slew;
    irq_events_s ev = '0;
    int n_errors = 0, cmp_count = 0, cyc = 0, n_ferr = 0, wake_m = 0, irq_m = 0, n, e, fire;
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) begin
        cyc++;
        n_ferr += (ferr === 1'b1);
        if (cyc == 40000) begin
            n_errors++;
            final_report();
        end
    end
    wake_and_interrupt_config #(.CAN_TO_SHORT_CYCLES(TO_S), .CAN_TO_LONG_CYCLES(TO_L),
        .INT_LONG_CYCLES(IL), .INT_SHORT_CYCLES(IS)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .frame_reset(frame_reset), .spi_cs_b(cs_b),
        .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
        .global_flags(flags), .frame_error(ferr), .io5_level(io5), .io5_wake(wake),
        .failsafe_output_b(fs_b), .failsafe_affects_can(fs_can), .can_rx_only(rx_only),
        .can_sleep(sleep), .can_wake_pattern_active(act), .can_wake_timeout(to),
        .battery_supply_below_7v(uv), .lin_force_recessive(rec), .lin_slew_mode(slew),
        .irq_events(ev), .int_b(int_b));
    spi_host_model host (.sys_clk(sys_clk), .spi_cs_b(cs_b), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic acc(input logic rw, input logic [5:0] a, input logic [7:0] dat);
        int x;
        x = a == ADDR_WAKE_CFG ? wake_m : a == ADDR_IRQ_CFG ? irq_m : 0;
        host.xfer({rw, a, ~^{rw, a, dat}, dat}, 16, rx);
        check(rx, {flags, x[7:0]});
        if (rw && a == ADDR_WAKE_CFG) wake_m = dat & 8'hF7;
        if (rw && a == ADDR_IRQ_CFG) irq_m = dat;
    endtask : acc
    task automatic outs();
        repeat (3) @(negedge sys_clk);
        check(wake, wake_m[7:6] == 1 ? io5 : wake_m[7:6] == 2 ? !io5 : 1'b0);
        check(slew, wake_m[1] ? SLEW_FAST : wake_m[0] ? SLEW_10K : SLEW_20K);
        check(rec, uv && !wake_m[2]);
        check({rx_only, sleep}, {2{!fs_b && fs_can}} & {!wake_m[5], wake_m[5]});
    endtask : outs
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(32'h32BFAA7B));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        acc(1'b0, ADDR_WAKE_CFG, 8'h00);
        acc(1'b0, ADDR_IRQ_CFG, 8'h00);
        for (int i = 0; i < 40; i++) begin
            flags = 8'($urandom);
            {io5, fs_b, fs_can, uv} = 4'($urandom);
            d = 8'($urandom);
            if (i % 2 == 0) d = {2'(i >> 1), d[5:2], 2'(i >> 1)};
            acc(1'b1, i % 2 ? ADDR_IRQ_CFG : ADDR_WAKE_CFG, d);
            outs();
            if (wake_m[7:6] == 3) begin
                io5 = !io5;
                n = 0;
                repeat (3) @(negedge sys_clk) n += (wake === 1'b1);
                check(n, 1);
            end
        end
        // A flipped parity bit and a short frame must both be refused.
        n = n_ferr;
        host.xfer(16'h87FF, 16, rx);
        host.xfer(16'h86FF, 15, rx);
        check(n_ferr - n, 2);
        acc(1'b1, 6'h05, 8'hFF);
        acc(1'b0, 6'h05, 8'h00);
        @(negedge sys_clk) frame_reset = 1'b1;
        @(negedge sys_clk) frame_reset = 1'b0;
        acc(1'b0, ADDR_WAKE_CFG, 8'h00);
        acc(1'b0, ADDR_IRQ_CFG, 8'h00);
        @(negedge sys_clk) rstn = 1'b0;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        wake_m = 0;
        irq_m = 0;
        repeat (2) @(negedge sys_clk);
        acc(1'b0, ADDR_WAKE_CFG, 8'h00);
        acc(1'b0, ADDR_IRQ_CFG, 8'h00);
        for (int k = 0; k < 28; k++) begin
            e = k % 7;
            acc(1'b1, ADDR_IRQ_CFG, 8'($urandom) & (k < 7 ? 8'hFF : 8'hDF));
            fire = !irq_m[5] && !(e == 5 ? irq_m[6] : e < 5 && irq_m[e]);
            ev = irq_events_s'(7'(1 << e));
            // The pulse starts at the edge that takes the strobe, so count from that cycle.
            n = 0;
            @(negedge sys_clk) ev = '0;
            n += (int_b === 1'b0);
            repeat (23) @(negedge sys_clk) n += (int_b === 1'b0);
            check(n, fire ? (irq_m[7] ? IS : IL) : 0);
        end
        for (int t = 0; t < 2; t++) begin
            acc(1'b1, ADDR_WAKE_CFG, t ? 8'h10 : 8'h00);
            act = 1'b1;
            n = 0;
            while (to !== 1'b1 && n < 80) begin
                @(posedge sys_clk);
                #1 n++;
            end
            check(n, t ? TO_L : TO_S);
            @(negedge sys_clk) act = 1'b0;
        end
        final_report();
    end
endmodule : wake_and_interrupt_config_tb
bind wake_and_interrupt_config wake_and_interrupt_config_properties #(
    .INT_LONG_CYCLES(INT_LONG_CYCLES), .INT_SHORT_CYCLES(INT_SHORT_CYCLES)) chk (
    .sys_clk(sys_clk), .rstn(rstn), .spi_cs_b(spi_cs_b), .spi_miso_oe(spi_miso_oe),
    .failsafe_output_b(failsafe_output_b), .failsafe_affects_can(failsafe_affects_can),
    .can_rx_only(can_rx_only), .can_sleep(can_sleep),
    .can_wake_pattern_active(can_wake_pattern_active), .can_wake_timeout(can_wake_timeout),
    .battery_supply_below_7v(battery_supply_below_7v), .lin_force_recessive(lin_force_recessive),
    .irq_events(irq_events), .int_b(int_b));
`default_nettype wire
